// ===== async_serial_ch1_rx_status.sv
// channel 1 status register and receive flag logic of the async serial unit
// assumes the receiver, transmitter and control register A sit outside and report
// their events as one-cycle pulses synchronous to clk_sys_in
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module async_serial_ch1_rx_status
  import serial_ch1_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // receive path events
  input wire logic rx_load_in,
  input wire logic rx_parity_bad_in,
  input wire logic rx_stop_bad_in,
  input wire logic rx_shift_full_in,
  input wire logic rx_data_read_in,
  // control register A and mode inputs
  input wire logic parity_select_in,
  input wire logic error_flag_reset_clear_in,
  input wire logic carrier_detect_in,
  input wire logic io_stop_mode_in,
  // transmit path events
  input wire logic tx_data_write_in,
  input wire logic tx_transfer_in,
  // shared pin and its two functions
  input wire logic shared_pin_in,
  output logic clear_to_send_out,
  output logic clocked_serial_rx_pin_out,
  // interrupts
  output logic rx_irq_out,
  output logic tx_irq_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic rx_irq_enable;
    logic clear_to_send_select;
    logic tx_irq_enable;
    logic tx_pending;
    logic tx_empty_flag;
    logic [RX_FLAG_COUNT-1:0] flags_prev;
    logic tx_empty_prev;
    logic [7:0] rdata;
    logic rx_irq;
    logic tx_irq;
    logic clear_to_send;
    logic csi_rx;
  } top_state_type;

  top_state_type state_q;
  top_state_type state_d;

  logic [RX_FLAG_COUNT-1:0] flag_set;
  logic [RX_FLAG_COUNT-1:0] flag_soft_clear;
  logic [RX_FLAG_COUNT-1:0] rx_flags;
  logic flag_hold_clear;
  logic [EVENT_COUNT-1:0] events;
  logic [EVENT_COUNT-1:0] irq_status;
  logic [EVENT_COUNT-1:0] irq_mask;
  logic irq_line;
  logic status_wr;
  logic irq_status_wr;
  logic irq_mask_wr;
  logic [7:0] status_view;
  logic cts_active;

  ////////////////////////////////////////////////////////////////////////////////
  // register decode

  assign status_wr = reg_wr_in && addr_hit(reg_addr_in, STATUS_OFFSET);
  assign irq_status_wr = reg_wr_in && addr_hit(reg_addr_in, IRQ_STATUS_OFFSET);
  assign irq_mask_wr = reg_wr_in && addr_hit(reg_addr_in, IRQ_MASK_OFFSET);

  ////////////////////////////////////////////////////////////////////////////////
  // receive flags

  // error bytes are loaded like good ones, so rx_full follows every load
  assign flag_set[FLAG_RX_FULL] = rx_load_in;
  // overrun compares against the flag as it stands, a same-cycle read still counts as unread
  assign flag_set[FLAG_OVERRUN] = rx_shift_full_in && rx_flags[FLAG_RX_FULL];
  assign flag_set[FLAG_PARITY] = rx_load_in && rx_parity_bad_in && parity_select_in;
  assign flag_set[FLAG_FRAMING] = rx_load_in && rx_stop_bad_in;

  assign flag_soft_clear[FLAG_RX_FULL] = rx_data_read_in;
  assign flag_soft_clear[FLAG_OVERRUN] = error_flag_reset_clear_in;
  assign flag_soft_clear[FLAG_PARITY] = error_flag_reset_clear_in;
  assign flag_soft_clear[FLAG_FRAMING] = error_flag_reset_clear_in;

  // carrier detect and stop mode keep the receiver in reset, so they beat any set
  assign flag_hold_clear = carrier_detect_in || io_stop_mode_in;

  sticky_flag_bank #(
    .WIDTH(RX_FLAG_COUNT)
  ) u_rx_flags (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .set_in(flag_set),
    .soft_clear_in(flag_soft_clear),
    .hold_clear_in(flag_hold_clear),
    .flags_out(rx_flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // events and interrupt block

  assign events = {state_q.tx_empty_flag && !state_q.tx_empty_prev, rx_flags & ~state_q.flags_prev};

  irq_event_block #(
    .WIDTH(EVENT_COUNT)
  ) u_irq (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .event_in(events),
    .status_wr_in(irq_status_wr),
    .mask_wr_in(irq_mask_wr),
    .wdata_in(reg_wdata_in[EVENT_COUNT-1:0]),
    .status_out(irq_status),
    .mask_out(irq_mask),
    .irq_out(irq_line)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // status view

  // the clear-to-send function only exists while the pin is routed to it
  assign cts_active = state_q.clear_to_send_select && shared_pin_in;

  always_comb begin
    status_view = STATUS_RESET;
    status_view[RX_FULL_BIT] = rx_flags[FLAG_RX_FULL];
    status_view[OVERRUN_BIT] = rx_flags[FLAG_OVERRUN];
    status_view[PARITY_ERR_BIT] = rx_flags[FLAG_PARITY];
    status_view[FRAMING_ERR_BIT] = rx_flags[FLAG_FRAMING];
    status_view[RX_IRQ_EN_BIT] = state_q.rx_irq_enable;
    status_view[CTS_SEL_BIT] = state_q.clear_to_send_select;
    status_view[TX_EMPTY_BIT] = state_q.tx_empty_flag;
    status_view[TX_IRQ_EN_BIT] = state_q.tx_irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;

    // only the enables and the select take written data
    if (status_wr) begin
      state_d.rx_irq_enable = reg_wdata_in[RX_IRQ_EN_BIT];
      state_d.clear_to_send_select = reg_wdata_in[CTS_SEL_BIT];
      state_d.tx_irq_enable = reg_wdata_in[TX_IRQ_EN_BIT];
    end

    // transmit holding register: a write in the transfer cycle refills it
    if (io_stop_mode_in) begin
      state_d.tx_pending = 1'b0;
    end else if (tx_data_write_in) begin
      state_d.tx_pending = 1'b1;
    end else if (tx_transfer_in) begin
      state_d.tx_pending = 1'b0;
    end
    state_d.tx_empty_flag = !state_d.tx_pending && !cts_active;

    state_d.flags_prev = rx_flags;
    state_d.tx_empty_prev = state_q.tx_empty_flag;

    // read data stand for one cycle only; a read has no side effect on the flags
    state_d.rdata = RDATA_IDLE;
    if (reg_rd_in) begin
      case (1'b1)
        addr_hit(reg_addr_in, STATUS_OFFSET): state_d.rdata = status_view;
        addr_hit(reg_addr_in, IRQ_STATUS_OFFSET): state_d.rdata = {3'h0, irq_status};
        addr_hit(reg_addr_in, IRQ_MASK_OFFSET): state_d.rdata = {3'h0, irq_mask};
        default: state_d.rdata = RDATA_IDLE;
      endcase
    end

    // request follows the flag level, so a still-set flag keeps asking
    state_d.rx_irq = state_d.rx_irq_enable && (|rx_flags);
    state_d.tx_irq = state_d.tx_irq_enable && state_d.tx_empty_flag;

    // the unselected function sees its idle level: cts low, serial rx high
    state_d.clear_to_send = cts_active;
    state_d.csi_rx = state_q.clear_to_send_select ? 1'b1 : shared_pin_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= '0;
      state_q.csi_rx <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out = state_q.rdata;
  assign clear_to_send_out = state_q.clear_to_send;
  assign clocked_serial_rx_pin_out = state_q.csi_rx;
  assign rx_irq_out = state_q.rx_irq;
  assign tx_irq_out = state_q.tx_irq;
  assign irq_out = irq_line;

endmodule : async_serial_ch1_rx_status
`default_nettype wire

// ===== irq_event_block.sv
// sticky event status with write-one-to-clear, a mask and one level interrupt
// assumes writes arrive as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module irq_event_block
  import serial_ch1_pkg::*;
#(
  parameter int unsigned WIDTH = 5
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // events and software access
  input wire logic [WIDTH-1:0] event_in,
  input wire logic status_wr_in,
  input wire logic mask_wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // state
  output logic [WIDTH-1:0] status_out,
  output logic [WIDTH-1:0] mask_out,
  output logic irq_out
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_check
    $error("irq_event_block width must be 1 to 8");
  end

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
    logic irq;
  } irq_state_type;

  irq_state_type state_q;
  irq_state_type state_d;

  always_comb begin
    state_d = state_q;
    // an event in the clearing cycle survives the clear
    if (status_wr_in) begin
      state_d.status = state_q.status & ~wdata_in;
    end
    state_d.status = state_d.status | event_in;
    if (mask_wr_in) begin
      state_d.mask = wdata_in;
    end
    state_d.irq = |(state_d.status & state_d.mask);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q.status <= WIDTH'(IRQ_STATUS_RESET);
      state_q.mask <= WIDTH'(IRQ_MASK_RESET);
      state_q.irq <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign status_out = state_q.status;
  assign mask_out = state_q.mask;
  assign irq_out = state_q.irq;

endmodule : irq_event_block
`default_nettype wire

// ===== rx_frame_source.sv
// far-side model: a remote sender as seen through the receive shifter
// assumes one-cycle go pulses from the bench and no overlapping frames
`timescale 1ns/100ps
`default_nettype none
module rx_frame_source (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // frame request
  input wire logic go_in,
  input wire logic bad_parity_in,
  input wire logic bad_stop_in,
  input wire logic [3:0] delay_in,
  // receive path events
  output logic shift_full_out = 1'b0,
  output logic load_out = 1'b0,
  output logic parity_bad_out = 1'b0,
  output logic stop_bad_out = 1'b0
);
  logic busy_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] err_q = 2'b00;
  always @(posedge clk_sys_in) begin
    // shifter fills first, the byte moves over one cycle later
    load_out <= shift_full_out;
    shift_full_out <= 1'b0;
    // qualifiers mean nothing outside a load, so they toggle there
    parity_bad_out <= shift_full_out ? err_q[1] : ~parity_bad_out;
    stop_bad_out <= shift_full_out ? err_q[0] : ~stop_bad_out;
    if (rst_in) begin
      busy_q <= 1'b0;
      load_out <= 1'b0;
    end else if (go_in) begin
      busy_q <= 1'b1;
      cnt_q <= delay_in;
      err_q <= {bad_parity_in, bad_stop_in};
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      shift_full_out <= 1'b1;
    end
  end
endmodule : rx_frame_source
`default_nettype wire

// ===== serial_ch1_pkg.sv
// constants for the channel 1 status register of the async serial unit
// assumes one 40 MHz clock and an 8-bit register port with read data one cycle late
//
// Behaviour
// - the 8-bit status register sits at I/O address 05h, bits 7..0 rx_full, overrun, parity error,
//   framing error, rx irq enable, clear-to-send select, tx_empty, tx irq enable, all reset to zero.
// - rx_full goes to one whenever a new byte is moved into the receive data register.
// - a byte with a framing or parity error is still loaded and still sets rx_full.
// - rx_full clears on a read of the receive data register, while carrier detect is high,
//   in I/O stop mode and in reset.
// - overrun sets when the shift register fills while the receive data register is still unread.
// - overrun clears on a zero written to error_flag_reset, while carrier detect is high,
//   in I/O stop mode and in reset.
// - parity error sets on a failed parity check, only while parity_select is one.
// - parity error clears like overrun.
// - framing error sets when the stop bit is seen as zero and clears like parity error.
// - with rx irq enable set, any set rx flag requests a receive interrupt.
// - clear-to-send select one routes the shared pin to clear-to-send, zero to the clocked serial rx pin.
// - tx_empty is held at zero while clear-to-send is high.
package serial_ch1_pkg;

  localparam logic [7:0] STATUS_OFFSET = 8'h05;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h11;

  localparam int unsigned RX_FULL_BIT = 7;
  localparam int unsigned OVERRUN_BIT = 6;
  localparam int unsigned PARITY_ERR_BIT = 5;
  localparam int unsigned FRAMING_ERR_BIT = 4;
  localparam int unsigned RX_IRQ_EN_BIT = 3;
  localparam int unsigned CTS_SEL_BIT = 2;
  localparam int unsigned TX_EMPTY_BIT = 1;
  localparam int unsigned TX_IRQ_EN_BIT = 0;

  localparam logic [7:0] STATUS_RESET = 8'h00;

  // rx flag vector order, low index first: framing, parity, overrun, rx_full
  localparam int unsigned RX_FLAG_COUNT = 4;
  localparam int unsigned FLAG_FRAMING = 0;
  localparam int unsigned FLAG_PARITY = 1;
  localparam int unsigned FLAG_OVERRUN = 2;
  localparam int unsigned FLAG_RX_FULL = 3;

  // event bits: the four rx flag risings, then tx_empty rising
  localparam int unsigned EVENT_COUNT = 5;
  localparam int unsigned EV_TX_EMPTY = 4;
  localparam logic [4:0] IRQ_STATUS_RESET = 5'h00;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

  localparam logic [7:0] RDATA_IDLE = 8'h00;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction : addr_hit

endpackage : serial_ch1_pkg

// ===== serial_ch1_properties.sv
// port-level checker for the channel 1 status block
// assumes one clock domain; bound onto the block's top module below
`timescale 1ns/100ps
`default_nettype none
module serial_ch1_properties (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // inputs watched
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic rx_load_in,
  input wire logic rx_shift_full_in,
  input wire logic rx_data_read_in,
  input wire logic error_flag_reset_clear_in,
  input wire logic carrier_detect_in,
  input wire logic io_stop_mode_in,
  input wire logic shared_pin_in,
  // outputs watched
  input wire logic [7:0] reg_rdata_out,
  input wire logic clear_to_send_out,
  input wire logic clocked_serial_rx_pin_out,
  input wire logic rx_irq_out,
  input wire logic tx_irq_out,
  input wire logic irq_out
);
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  a_cts_gate: assert property (!$past(shared_pin_in) |-> !clear_to_send_out)
    else $error("clear to send without pin");
  a_rxpin_route: assert property ($past(shared_pin_in) |-> clocked_serial_rx_pin_out)
    else $error("serial rx pin low with pin high");
  a_hold_clear: assert property ((carrier_detect_in || io_stop_mode_in) [*2] |=> !rx_irq_out)
    else $error("rx irq during hold clear");
  a_tx_cts_block: assert property (clear_to_send_out [*3] |-> !tx_irq_out)
    else $error("tx irq while clear to send high");
  a_rx_irq_cause: assert property ($rose(rx_irq_out) |->
      $past(rx_load_in, 2) || $past(rx_shift_full_in, 2) || $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("rx irq rose without cause");
  a_rx_irq_drop: assert property ($fell(rx_irq_out) |-> $past(rx_data_read_in, 2) ||
      $past(error_flag_reset_clear_in, 2) || $past(carrier_detect_in, 2) || $past(io_stop_mode_in, 2) ||
      $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("rx irq fell without clear");
  a_irq_sticky: assert property ($fell(irq_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("event irq fell without write");
  c_rx_irq: cover property (rx_irq_out);
  c_irq: cover property (irq_out);
  c_cts: cover property (clear_to_send_out [*3]);
endmodule : serial_ch1_properties
bind async_serial_ch1_rx_status serial_ch1_properties props (.clk_sys_in, .rst_in, .reg_wr_in, .reg_rd_in,
  .rx_load_in, .rx_shift_full_in, .rx_data_read_in, .error_flag_reset_clear_in, .carrier_detect_in,
  .io_stop_mode_in, .shared_pin_in, .reg_rdata_out, .clear_to_send_out, .clocked_serial_rx_pin_out,
  .rx_irq_out, .tx_irq_out, .irq_out);
`default_nettype wire

// ===== sticky_flag_bank.sv
// bank of sticky flags with a per-bit soft clear and a common hold clear
// assumes all inputs synchronous to clk_sys_in
`timescale 1ns/100ps
`default_nettype none
module sticky_flag_bank
  import serial_ch1_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // flag control
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] soft_clear_in,
  input wire logic hold_clear_in,
  // flag state
  output logic [WIDTH-1:0] flags_out
);

  if (WIDTH < 1) begin : g_check
    $error("sticky_flag_bank needs at least one flag");
  end

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_type;

  bank_state_type state_q;
  bank_state_type state_d;
  logic [WIDTH-1:0] next_flags;

  // a set in the same cycle as a soft clear wins; a hold clear wins over everything
  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    assign next_flags[i] = hold_clear_in ? 1'b0 :
                           set_in[i] ? 1'b1 :
                           soft_clear_in[i] ? 1'b0 : state_q.flags[i];
  end

  always_comb begin
    state_d = state_q;
    state_d.flags = next_flags;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags_out = state_q.flags;

endmodule : sticky_flag_bank
`default_nettype wire

// ===== tb.sv
// self-checking bench for the channel 1 status block
// assumes the far-side model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module tb;
  import serial_ch1_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, go = 1'b0, gp = 1'b0, gs = 1'b0, psel = 1'b0, pin = 1'b0;
  logic [5:0] pl = 6'h00;
  logic [3:0] dly = 4'h0;
  logic load, pbad, sbad, sfull, cts, clocked_serial_rx_pin, rirq, tirq, irq;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  // pl: rx data read, error reset, tx write, tx transfer, carrier, io stop
  async_serial_ch1_rx_status uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_load_in(load),
    .rx_parity_bad_in(pbad), .rx_stop_bad_in(sbad), .rx_shift_full_in(sfull), .rx_data_read_in(pl[0]),
    .parity_select_in(psel), .error_flag_reset_clear_in(pl[1]), .carrier_detect_in(pl[4]),
    .io_stop_mode_in(pl[5]), .tx_data_write_in(pl[2]), .tx_transfer_in(pl[3]), .shared_pin_in(pin),
    .clear_to_send_out(cts), .clocked_serial_rx_pin_out(clocked_serial_rx_pin), .rx_irq_out(rirq), .tx_irq_out(tirq),
    .irq_out(irq));
  rx_frame_source far (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .go_in(go), .bad_parity_in(gp),
    .bad_stop_in(gs), .delay_in(dly), .shift_full_out(sfull), .load_out(load), .parity_bad_out(pbad),
    .stop_bad_out(sbad));
  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8
  // outputs are registered, so let two edges land before looking; by reference so the late value is seen
  task automatic cmp1(ref logic got_now, input logic exp);
    repeat (2) @(posedge clk_sys_in);
    #1;
    cmp8({7'h00, got_now}, {7'h00, exp});
  endtask : cmp1
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    cmp8(rdata, exp);
  endtask : rd_reg
  task automatic pulse(input int i, input int n);
    @(posedge clk_sys_in);
    pl[i] <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    pl[i] <= 1'b0;
  endtask : pulse
  task automatic frame(input logic p, input logic s, input logic [3:0] d);
    @(posedge clk_sys_in);
    gp <= p;
    gs <= s;
    dly <= d;
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    repeat (int'(d) + 7) @(posedge clk_sys_in);
  endtask : frame
  ////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_reg(STATUS_OFFSET, 8'h02);
    rd_reg(8'h06, 8'h00);
    wr_reg(STATUS_OFFSET, 8'hff);
    rd_reg(STATUS_OFFSET, 8'h0f);
    cmp1(tirq, 1'b1);
    wr_reg(STATUS_OFFSET, 8'h00);
    frame(1'b0, 1'b1, 4'h0);
    rd_reg(STATUS_OFFSET, 8'h92);
    rd_reg(STATUS_OFFSET, 8'h92);
    cmp1(irq, 1'b0);
    pulse(0, 1);
    rd_reg(STATUS_OFFSET, 8'h12);
    pulse(1, 1);
    rd_reg(STATUS_OFFSET, 8'h02);
    frame(1'b1, 1'b0, 4'h5);
    rd_reg(STATUS_OFFSET, 8'h82);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    frame(1'b1, 1'b0, 4'h0);
    rd_reg(STATUS_OFFSET, 8'he2);
    pulse(1, 1);
    rd_reg(STATUS_OFFSET, 8'h82);
    frame(1'b0, 1'b0, 4'h2);
    rd_reg(STATUS_OFFSET, 8'hc2);
    pulse(4, 2);
    rd_reg(STATUS_OFFSET, 8'h02);
    frame(1'b0, 1'b1, 4'h0);
    pulse(5, 2);
    rd_reg(STATUS_OFFSET, 8'h02);
    wr_reg(STATUS_OFFSET, 8'h08);
    frame(1'b0, 1'b0, 4'h3);
    cmp1(rirq, 1'b1);
    rd_reg(STATUS_OFFSET, 8'h8a);
    pulse(0, 1);
    cmp1(rirq, 1'b0);
    rd_reg(IRQ_STATUS_OFFSET, 8'h1f);
    wr_reg(IRQ_MASK_OFFSET, 8'h08);
    cmp1(irq, 1'b1);
    wr_reg(IRQ_STATUS_OFFSET, 8'h1f);
    cmp1(irq, 1'b0);
    frame(1'b0, 1'b0, 4'h0);
    cmp1(irq, 1'b1);
    pulse(0, 1);
    wr_reg(STATUS_OFFSET, 8'h05);
    cmp1(tirq, 1'b1);
    @(posedge clk_sys_in);
    pin <= 1'b1;
    cmp1(cts, 1'b1);
    rd_reg(STATUS_OFFSET, 8'h05);
    cmp1(tirq, 1'b0);
    @(posedge clk_sys_in);
    pin <= 1'b0;
    cmp1(clocked_serial_rx_pin, 1'b1);
    wr_reg(STATUS_OFFSET, 8'h01);
    cmp1(clocked_serial_rx_pin, 1'b0);
    rd_reg(STATUS_OFFSET, 8'h03);
    pulse(2, 1);
    rd_reg(STATUS_OFFSET, 8'h01);
    pulse(3, 1);
    rd_reg(STATUS_OFFSET, 8'h03);
    // mid-run reset with flags standing: everything clears, tx_empty returns one edge later
    frame(1'b1, 1'b1, 4'h0);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_reg(STATUS_OFFSET, 8'h02);
    rd_reg(IRQ_STATUS_OFFSET, 8'h10);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
